// *** sac_pkg.sv ***
`default_nettype none
package sac_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CH_W   = 4;
  localparam int MUX_W  = 11;
  localparam int EXT_N  = 8;

  localparam logic [7:0] OFF_PORT     = 8'h03;
  localparam logic [7:0] OFF_RESULT   = 8'h08;
  localparam logic [7:0] OFF_STATCTL  = 8'h09;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h11;

  localparam int BIT_DONE = 7;
  localparam int BIT_RC   = 6;
  localparam int BIT_PWR  = 5;
  localparam int BIT_IRQ_DONE = 0;

  localparam logic [7:0] RESET_RESULT = 8'h00;
  localparam logic [3:0] RESET_CH     = 4'h0;
  localparam logic [7:0] READ_ZERO    = 8'h00;

  localparam logic [3:0] CH_REF_HI  = 4'h8;
  localparam logic [3:0] CH_REF_MID = 4'h9;
  localparam int MUX_REF_HI  = 8;
  localparam int MUX_REF_MID = 9;
  localparam int MUX_REF_LO  = 10;

  localparam logic [3:0] SAMPLE_TICKS = 4'hC;
  localparam logic [3:0] BIT_TICKS    = 4'h4;
  localparam logic [7:0] SAR_MSB      = 8'h80;
  localparam logic [7:0] SAR_ONE      = 8'h01;
  localparam logic [2:0] SAR_TOP_BIT  = 3'h7;
  localparam int RC_DIV = 4;
endpackage
`default_nettype wire

// *** sac_tick.sv ***
`default_nettype none
module sac_tick #(
  parameter int RC_DIV = sac_pkg::RC_DIV
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic rc_sel,
  output logic      tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } sac_tick_state_t;

  sac_tick_state_t st_reg;
  sac_tick_state_t st_next;

  // The RC clock is modelled as a slower enable so the block keeps one clock.
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = 8'h00;
    end else if (!rc_sel) begin
      st_next.tick = 1'b1;
      st_next.cnt = 8'h00;
    end else if (st_reg.cnt == 8'(RC_DIV - 1)) begin
      st_next.tick = 1'b1;
      st_next.cnt = 8'h00;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule // sac_tick
`default_nettype wire

// *** sac_sar.sv ***
`default_nettype none
module sac_sar (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       start,
  input  wire logic       tick,
  input  wire logic       comp,
  output logic [7:0]      dac_code,
  output logic            sample,
  output logic            done,
  output logic [7:0]      result
);
  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONV} sac_sar_phase_t;

  typedef struct packed {
    sac_sar_phase_t phase;
    logic [3:0]     cnt;
    logic [2:0]     bitn;
    logic [7:0]     code;
    logic           sample;
    logic           done;
    logic [7:0]     result;
  } sac_sar_state_t;

  sac_sar_state_t st_reg;
  sac_sar_state_t st_next;
  logic [7:0]     kept;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    kept = comp ? st_reg.code : (st_reg.code & ~(sac_pkg::SAR_ONE << st_reg.bitn));
    if (!run) begin
      st_next.phase = S_IDLE;
      st_next.code = 8'h00;
      st_next.sample = 1'b0;
      st_next.cnt = 4'h0;
    end else if (start) begin
      st_next.phase = S_SAMPLE;
      st_next.code = 8'h00;
      st_next.sample = 1'b1;
      st_next.cnt = 4'h0;
    end else begin
      case (st_reg.phase)
        S_IDLE: begin
          st_next.phase = S_SAMPLE;
          st_next.sample = 1'b1;
          st_next.cnt = 4'h0;
        end
        S_SAMPLE: begin
          if (tick) begin
            if (st_reg.cnt == sac_pkg::SAMPLE_TICKS - 4'h1) begin
              st_next.phase = S_CONV;
              st_next.sample = 1'b0;
              st_next.bitn = sac_pkg::SAR_TOP_BIT;
              st_next.code = sac_pkg::SAR_MSB;
              st_next.cnt = 4'h0;
            end else begin
              st_next.cnt = st_reg.cnt + 4'h1;
            end
          end
        end
        S_CONV: begin
          if (tick) begin
            if (st_reg.cnt == sac_pkg::BIT_TICKS - 4'h1) begin
              st_next.cnt = 4'h0;
              if (st_reg.bitn == 3'h0) begin
                st_next.done = 1'b1;
                st_next.result = kept;
                st_next.phase = S_SAMPLE;
                st_next.sample = 1'b1;
                st_next.code = 8'h00;
              end else begin
                st_next.bitn = st_reg.bitn - 3'h1;
                st_next.code = kept | (sac_pkg::SAR_ONE << (st_reg.bitn - 3'h1));
              end
            end else begin
              st_next.cnt = st_reg.cnt + 4'h1;
            end
          end
        end
        default: begin
          st_next.phase = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dac_code = st_reg.code;
  assign sample   = st_reg.sample;
  assign done     = st_reg.done;
  assign result   = st_reg.result;
endmodule // sac_sar
`default_nettype wire

// *** sac_adc.sv ***
// Strobed register access was left to the implementer.
`default_nettype none
module sac_adc #(
  parameter int RC_DIV = sac_pkg::RC_DIV
) (
  input  wire logic                        SYS_CLK,
  input  wire logic                        SYS_RST,
  input  wire logic [sac_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [sac_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [sac_pkg::DATA_W-1:0]  RDATA,
  input  wire logic [sac_pkg::EXT_N-1:0]   PORT_PINS,
  input  wire logic                        COMP_IN,
  input  wire logic                        STOP_ACTIVE,
  output logic      [sac_pkg::MUX_W-1:0]   MUX_SEL,
  output logic                             SAMPLE_SW,
  output logic      [7:0]                  DAC_CODE,
  output logic                             CONV_POWER,
  output logic                             RC_OSC_EN,
  output logic                             IRQ
);
  typedef struct packed {
    logic [sac_pkg::EXT_N-1:0]  pins_s1;
    logic [sac_pkg::EXT_N-1:0]  pins_s2;
    logic                       comp_s1;
    logic                       comp_s2;
    logic                       rc_sel;
    logic                       pwr_on;
    logic                       done_flag;
    logic [sac_pkg::CH_W-1:0]   channel;
    logic [7:0]                 result;
    logic                       irq_stat;
    logic                       irq_mask;
    logic [sac_pkg::DATA_W-1:0] rdata;
    logic [sac_pkg::MUX_W-1:0]  mux_sel;
    logic                       rc_osc;
    logic                       conv_pwr;
    logic                       irq;
  } sac_top_state_t;

  sac_top_state_t st_reg;
  sac_top_state_t st_next;

  logic                      wr_ctl;
  logic                      wr_mask;
  logic                      wr_istat;
  logic                      rd_result;
  logic                      run;
  logic                      tick;
  logic                      sar_done;
  logic [7:0]                sar_result;
  logic [7:0]                sar_code;
  logic                      sar_sample;
  logic [sac_pkg::EXT_N-1:0] ext_hit;
  logic                      is_ref_hi;
  logic                      is_ref_mid;

  // Stop holds the tick and the conversion engine idle; the system keeps it high through its start-up delay.
  assign run = st_reg.pwr_on & ~STOP_ACTIVE;

  // Exact decode keeps writes to the port and result offsets from touching the engine.
  assign wr_ctl    = WR && (ADDR == sac_pkg::OFF_STATCTL);
  assign wr_mask   = WR && (ADDR == sac_pkg::OFF_IRQ_MASK);
  assign wr_istat  = WR && (ADDR == sac_pkg::OFF_IRQ_STAT);
  assign rd_result = RD && (ADDR == sac_pkg::OFF_RESULT);

  sac_tick #(
    .RC_DIV (RC_DIV)
  ) u_tick (
    .clk    (SYS_CLK),
    .rst    (SYS_RST),
    .run    (run),
    .rc_sel (st_reg.rc_sel),
    .tick   (tick)
  );

  // A comparator high means the held input is at or above the trial code.
  sac_sar u_sar (
    .clk      (SYS_CLK),
    .rst      (SYS_RST),
    .run      (run),
    .start    (wr_ctl),
    .tick     (tick),
    .comp     (st_reg.comp_s2),
    .dac_code (sar_code),
    .sample   (sar_sample),
    .done     (sar_done),
    .result   (sar_result)
  );

  genvar gi;
  generate
    for (gi = 0; gi < sac_pkg::EXT_N; gi++) begin : g_ext
      assign ext_hit[gi] = (st_reg.channel == sac_pkg::CH_W'(gi));
    end
  endgenerate

  assign is_ref_hi  = (st_reg.channel == sac_pkg::CH_REF_HI);
  assign is_ref_mid = (st_reg.channel == sac_pkg::CH_REF_MID);

  always_comb begin
    st_next = st_reg;

    // Only the second stage is read by any logic.
    st_next.pins_s1 = PORT_PINS;
    st_next.pins_s2 = st_reg.pins_s1;
    st_next.comp_s1 = COMP_IN;
    st_next.comp_s2 = st_reg.comp_s1;

    // The selector follows the channel one cycle late; sampling lasts far longer.
    st_next.mux_sel = '0;
    st_next.mux_sel[sac_pkg::EXT_N-1:0] = ext_hit;
    st_next.mux_sel[sac_pkg::MUX_REF_HI] = is_ref_hi;
    st_next.mux_sel[sac_pkg::MUX_REF_MID] = is_ref_mid;
    st_next.mux_sel[sac_pkg::MUX_REF_LO] = st_reg.channel[sac_pkg::CH_W-1] & ~is_ref_hi & ~is_ref_mid;

    if (wr_ctl) begin
      st_next.rc_sel = WDATA[sac_pkg::BIT_RC];
      st_next.pwr_on = WDATA[sac_pkg::BIT_PWR];
      st_next.channel = WDATA[sac_pkg::CH_W-1:0];
      st_next.done_flag = 1'b0;
    end
    if (rd_result) begin
      st_next.done_flag = 1'b0;
    end
    if (wr_mask) begin
      st_next.irq_mask = WDATA[sac_pkg::BIT_IRQ_DONE];
    end
    if (wr_istat && WDATA[sac_pkg::BIT_IRQ_DONE]) begin
      st_next.irq_stat = 1'b0;
    end

    // A finishing conversion wins over any clear in the same cycle.
    if (sar_done) begin
      st_next.result = sar_result;
      st_next.done_flag = 1'b1;
      st_next.irq_stat = 1'b1;
    end

    st_next.rdata = sac_pkg::READ_ZERO;
    if (RD) begin
      case (ADDR)
        sac_pkg::OFF_PORT: begin
          // Reading here during a conversion may cost accuracy on the pins.
          st_next.rdata = st_reg.pins_s2;
        end
        sac_pkg::OFF_RESULT: begin
          st_next.rdata = st_reg.result;
        end
        sac_pkg::OFF_STATCTL: begin
          st_next.rdata[sac_pkg::BIT_DONE] = st_reg.done_flag;
          st_next.rdata[sac_pkg::BIT_RC] = st_reg.rc_sel;
          st_next.rdata[sac_pkg::BIT_PWR] = st_reg.pwr_on;
          st_next.rdata[sac_pkg::CH_W-1:0] = st_reg.channel;
        end
        sac_pkg::OFF_IRQ_STAT: begin
          st_next.rdata[sac_pkg::BIT_IRQ_DONE] = st_reg.irq_stat;
        end
        sac_pkg::OFF_IRQ_MASK: begin
          st_next.rdata[sac_pkg::BIT_IRQ_DONE] = st_reg.irq_mask;
        end
        default: begin
          st_next.rdata = sac_pkg::READ_ZERO;
        end
      endcase
    end

    st_next.rc_osc = st_next.rc_sel & ~STOP_ACTIVE;
    st_next.conv_pwr = st_next.pwr_on & ~STOP_ACTIVE;
    st_next.irq = st_next.irq_stat & st_next.irq_mask;
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA      = st_reg.rdata;
  assign MUX_SEL    = st_reg.mux_sel;
  assign SAMPLE_SW  = sar_sample;
  assign DAC_CODE   = sar_code;
  assign CONV_POWER = st_reg.conv_pwr;
  assign RC_OSC_EN  = st_reg.rc_osc;
  assign IRQ        = st_reg.irq;
endmodule // sac_adc
`default_nettype wire

// *** sac_adc_properties.sv ***
`default_nettype none
module sac_adc_properties #(
  parameter int RC_DIV = 4
) (
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  input wire logic [7:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  input wire logic [7:0]  PORT_PINS,
  input wire logic        COMP_IN,
  input wire logic        STOP_ACTIVE,
  input wire logic [10:0] MUX_SEL,
  input wire logic        SAMPLE_SW,
  input wire logic [7:0]  DAC_CODE,
  input wire logic        CONV_POWER,
  input wire logic        RC_OSC_EN,
  input wire logic        IRQ
);
  wire logic ctl_wr;
  assign ctl_wr = WR && (ADDR == sac_pkg::OFF_STATCTL);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // A control write or stop during sampling restarts or halts it, so only quiet windows are timed.
  sequence s_quiet12;
    (!ctl_wr && !STOP_ACTIVE)[*8] ##1 (!ctl_wr && !STOP_ACTIVE)[*4];
  endsequence
  sequence s_sample_start;
    $rose(SAMPLE_SW) && !RC_OSC_EN;
  endsequence
  property p_sample;
    s_sample_start ##0 s_quiet12 |=> !SAMPLE_SW && $past(SAMPLE_SW);
  endproperty
  property p_first_trial;
    $fell(SAMPLE_SW) && CONV_POWER && !$past(ctl_wr) && !STOP_ACTIVE && !$past(STOP_ACTIVE)
      |-> DAC_CODE == sac_pkg::SAR_MSB;
  endproperty
  property p_restart;
    ctl_wr && WDATA[sac_pkg::BIT_PWR] && CONV_POWER && !STOP_ACTIVE |=> SAMPLE_SW;
  endproperty
  property p_ctl_follow;
    ctl_wr && !STOP_ACTIVE |=> CONV_POWER == $past(WDATA[sac_pkg::BIT_PWR]) && RC_OSC_EN == $past(WDATA[sac_pkg::BIT_RC]);
  endproperty
  property p_off_idle;
    !CONV_POWER && !$past(CONV_POWER) |-> DAC_CODE == 8'h00 && !SAMPLE_SW;
  endproperty
  property p_stop;
    STOP_ACTIVE |=> !CONV_POWER && !RC_OSC_EN;
  endproperty
  property p_ref_hi;
    ctl_wr && WDATA[sac_pkg::BIT_PWR] && WDATA[3:0] == sac_pkg::CH_REF_HI |-> ##[1:2] MUX_SEL == 11'h100;
  endproperty
  property p_ref_lo;
    ctl_wr && WDATA[sac_pkg::BIT_PWR] && WDATA[3:0] > sac_pkg::CH_REF_MID |-> ##[1:2] MUX_SEL == 11'h400;
  endproperty
  property p_done_rd;
    RD && ADDR == sac_pkg::OFF_RESULT ##2 RD && ADDR == sac_pkg::OFF_STATCTL |=> !RDATA[sac_pkg::BIT_DONE];
  endproperty
  property p_done_wr;
    ctl_wr ##2 RD && ADDR == sac_pkg::OFF_STATCTL |=> !RDATA[sac_pkg::BIT_DONE];
  endproperty
  a_sample: assert property (p_sample) else $error("Sampling not twelve cycles");
  a_first_trial: assert property (p_first_trial) else $error("First trial code wrong");
  a_restart: assert property (p_restart) else $error("No restart after control write");
  a_ctl_follow: assert property (p_ctl_follow) else $error("Power or RC enable wrong");
  a_off_idle: assert property (p_off_idle) else $error("Engine active while off");
  a_stop: assert property (p_stop) else $error("Converter active in stop");
  a_ref_hi: assert property (p_ref_hi) else $error("High reference not selected");
  a_ref_lo: assert property (p_ref_lo) else $error("Low reference not selected");
  a_done_rd: assert property (p_done_rd) else $error("Done flag kept after result read");
  a_done_wr: assert property (p_done_wr) else $error("Done flag kept after control write");
endmodule // sac_adc_properties
bind sac_adc sac_adc_properties #(.RC_DIV(RC_DIV)) u_props (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .PORT_PINS(PORT_PINS), .COMP_IN(COMP_IN), .STOP_ACTIVE(STOP_ACTIVE),
  .MUX_SEL(MUX_SEL), .SAMPLE_SW(SAMPLE_SW), .DAC_CODE(DAC_CODE), .CONV_POWER(CONV_POWER),
  .RC_OSC_EN(RC_OSC_EN), .IRQ(IRQ));
`default_nettype wire

// *** sac_analog_model.sv ***
`default_nettype none
module sac_analog_model (
  input  wire logic        clk,
  input  wire logic [10:0] mux_sel,
  input  wire logic        sample_sw,
  input  wire logic [7:0]  dac_code,
  input  wire logic [63:0] levels,
  output logic             comp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] held;
  initial held = 8'h00;
  always @(posedge clk) begin
    if (sample_sw) begin
      held <= 8'h00;
      for (int i = 0; i < 8; i++)
        if (mux_sel[i]) held <= levels[i*8 +: 8];
      if (mux_sel[8]) held <= 8'hFF;
      if (mux_sel[9]) held <= 8'h80;
    end
  end
  // The held value stays after the switch opens, as on the sampling capacitor.
  assign comp = held >= dac_code;
endmodule // sac_analog_model
`default_nettype wire

// *** sac_adc_bench.sv ***
`default_nettype none
module sac_adc_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        SYS_CLK, SYS_RST, WR, RD, COMP_IN, STOP_ACTIVE, SAMPLE_SW, CONV_POWER, RC_OSC_EN, IRQ;
  logic [7:0]  ADDR, WDATA, RDATA, PORT_PINS, DAC_CODE, d;
  logic [10:0] MUX_SEL;
  logic [63:0] levels;
  int          failures, comparisons;
  sac_adc #(.RC_DIV(2)) i_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PORT_PINS(PORT_PINS), .COMP_IN(COMP_IN), .STOP_ACTIVE(STOP_ACTIVE),
    .MUX_SEL(MUX_SEL), .SAMPLE_SW(SAMPLE_SW), .DAC_CODE(DAC_CODE), .CONV_POWER(CONV_POWER),
    .RC_OSC_EN(RC_OSC_EN), .IRQ(IRQ));
  sac_analog_model i_model (.clk(SYS_CLK), .mux_sel(MUX_SEL), .sample_sw(SAMPLE_SW), .dac_code(DAC_CODE),
    .levels(levels), .comp(COMP_IN));
  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  function automatic logic [7:0] lvl(input int c);
    if (c < 8) return 8'(8'h1D * (c + 1));
    if (c == 8) return 8'hFF;
    if (c == 9) return 8'h80;
    return 8'h00;
  endfunction
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  // Polling is bounded so that a converter that never finishes ends the run.
  task automatic wait_done;
    for (int n = 0; n < 200; n++) begin
      rd(sac_pkg::OFF_STATCTL);
      if (d[sac_pkg::BIT_DONE] === 1'b1) return;
    end
    failures++;
    tally_and_finish;
  endtask
  task automatic conv(input int c, input logic [7:0] ctl);
    wr(sac_pkg::OFF_STATCTL, ctl | 8'(c));
    wait_done;
    chk8(d, 8'h80 | ctl | 8'(c));
    rd(sac_pkg::OFF_RESULT);
    chk8(d, lvl(c));
    rd(sac_pkg::OFF_STATCTL);
    chk8(d, ctl | 8'(c));
  endtask
  initial begin
    SYS_RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
    STOP_ACTIVE = 1'b0;
    PORT_PINS = 8'hA5;
    failures = 0;
    comparisons = 0;
    for (int i = 0; i < 8; i++) levels[i*8 +: 8] = lvl(i);
    repeat (16) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    rd(sac_pkg::OFF_RESULT);
    chk8(d, 8'h00);
    rd(sac_pkg::OFF_STATCTL);
    chk8(d, 8'h00);
    rd(8'h20);
    chk8(d, 8'h00);
    rd(sac_pkg::OFF_PORT);
    chk8(d, 8'hA5);
    for (int c = 0; c < 16; c++) conv(c, 8'h20);
    // No write since the last check, so the done flag setting again proves the engine restarted by itself.
    wait_done;
    rd(sac_pkg::OFF_RESULT);
    chk8(d, lvl(15));
    @(posedge SYS_CLK);
    PORT_PINS <= 8'h3C;
    repeat (3) @(posedge SYS_CLK);
    rd(sac_pkg::OFF_PORT);
    chk8(d, 8'h3C);
    wr(sac_pkg::OFF_STATCTL, 8'h21);
    repeat (20) @(posedge SYS_CLK);
    conv(2, 8'h20);
    wr(sac_pkg::OFF_STATCTL, 8'h23);
    repeat (20) @(posedge SYS_CLK);
    wr(sac_pkg::OFF_RESULT, 8'h55);
    wr(sac_pkg::OFF_PORT, 8'h55);
    // The channel three conversion is still running, so the old result must stand.
    rd(sac_pkg::OFF_RESULT);
    chk8(d, lvl(2));
    wait_done;
    rd(sac_pkg::OFF_RESULT);
    chk8(d, lvl(3));
    conv(4, 8'h60);
    chk1(RC_OSC_EN, 1'b1);
    @(posedge SYS_CLK);
    STOP_ACTIVE <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    chk1(CONV_POWER, 1'b0);
    chk1(RC_OSC_EN, 1'b0);
    chk8(DAC_CODE, 8'h00);
    STOP_ACTIVE <= 1'b0;
    wait_done;
    rd(sac_pkg::OFF_RESULT);
    chk8(d, lvl(4));
    wr(sac_pkg::OFF_STATCTL, 8'h00);
    repeat (3) @(posedge SYS_CLK);
    chk1(CONV_POWER, 1'b0);
    chk8(DAC_CODE, 8'h00);
    wr(sac_pkg::OFF_IRQ_MASK, 8'h01);
    repeat (2) @(posedge SYS_CLK);
    chk1(IRQ, 1'b1);
    rd(sac_pkg::OFF_IRQ_STAT);
    chk8(d, 8'h01);
    wr(sac_pkg::OFF_IRQ_MASK, 8'h00);
    repeat (2) @(posedge SYS_CLK);
    chk1(IRQ, 1'b0);
    wr(sac_pkg::OFF_IRQ_MASK, 8'h01);
    wr(sac_pkg::OFF_IRQ_STAT, 8'h01);
    repeat (2) @(posedge SYS_CLK);
    chk1(IRQ, 1'b0);
    rd(sac_pkg::OFF_IRQ_STAT);
    chk8(d, 8'h00);
    wr(sac_pkg::OFF_STATCTL, 8'h65);
    wait_done;
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    rd(sac_pkg::OFF_RESULT);
    chk8(d, 8'h00);
    rd(sac_pkg::OFF_STATCTL);
    chk8(d, 8'h00);
    chk1(CONV_POWER, 1'b0);
    tally_and_finish;
  end
endmodule // sac_adc_bench
`default_nettype wire
